// ==== tct_pkg.sv ====
package tct_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned MS_TIME_NS    = 1000000;
    localparam int unsigned TICK_CYCLES   = MS_TIME_NS / CLK_PERIOD_NS;
    localparam logic [14:0] MS_PER_SEC    = 15'h03e8;
    localparam logic [13:0] PERIOD_CAP    = 14'h3ffc;
    localparam logic [13:0] PERIOD_MAX    = 14'h3e80;
    localparam logic [4:0]  SPAN_MIN      = 5'h01;
    localparam logic [4:0]  SPAN_MAX      = 5'h10;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_PERIOD  = 8'h04;
    localparam logic [7:0] OFF_RDELAY  = 8'h08;
    localparam logic [7:0] OFF_HOLD    = 8'h0c;
    localparam logic [7:0] OFF_WIDTH   = 8'h10;
    localparam logic [7:0] OFF_BLOCK   = 8'h14;
    localparam logic [7:0] OFF_INHIBIT = 8'h18;
    localparam logic [7:0] OFF_EARLY   = 8'h1c;
    localparam logic [7:0] OFF_LATE    = 8'h20;
    localparam logic [7:0] OFF_EXTN    = 8'h24;
    localparam logic [7:0] OFF_FRATE   = 8'h28;
    localparam logic [7:0] OFF_FCOUNT  = 8'h2c;
    localparam logic [7:0] OFF_CMD     = 8'h30;
    localparam logic [7:0] OFF_STATUS  = 8'h34;

    // ----------------------------------------
    // Command fields
    // ----------------------------------------
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_STOP = 2'h1;
    localparam logic [1:0] CMD_RUN  = 2'h2;
    localparam logic [1:0] CMD_HOLD = 2'h3;
    localparam int unsigned CMD_ADV_BIT = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [13:0] PERIOD_RST = 14'h01f4;
    localparam logic [7:0]  EXTN_RST   = 8'h01;
    localparam logic [7:0]  FCOUNT_RST = 8'h01;

    typedef enum logic [2:0] {
        ST_STOP = 3'b001,
        ST_RUN  = 3'b010,
        ST_HOLD = 3'b100
    } tct_state_t;

    typedef struct packed {
        logic        late_en;
        logic        early_en;
        logic        strict;
        logic        fixed_en;
        logic        ext_mode;
        logic        inhibit_en;
        logic        delay_en;
    } tct_ctrl_t;

    typedef struct packed {
        tct_ctrl_t   ctrl;
        logic [13:0] period;
        logic [13:0] rec_delay;
        logic [4:0]  hold_sec;
        logic [4:0]  width;
        logic [13:0] block;
        logic [13:0] inhibit;
        logic [14:0] early;
        logic [7:0]  late;
        logic [7:0]  ext_n;
        logic [13:0] fixed_rate;
        logic [7:0]  fixed_count;
    } tct_cfg_t;

endpackage

// ==== tct_timebase.sv ====
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module tct_timebase #(
    parameter int unsigned TICK_CYCLES = tct_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    // AXI4-Lite slave
    input  wire logic [7:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic [7:0]  S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    // Pins
    input  wire logic        EXT_TRIG_I,
    input  wire logic        INH_START_I,
    input  wire logic        SAFE_LOOP_I,
    output logic             SRC_TRIG_O,
    output logic             REC_TRIG_O,
    output logic             ALARM_O
);

    tct_pkg::tct_cfg_t   cfg;
    tct_pkg::tct_state_t state;
    logic [15:0] tick_cnt;
    logic        tick;
    logic [2:0]  s1, s2, s3, pin_q, pin_d;
    logic        aw_held, w_held, do_write;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        cmd_go, cmd_adv;
    logic [1:0]  cmd_code;
    logic [14:0] tb_cnt, cur_period, end_limit;
    logic        tb_wrap, ext_fire, fixed_now, fire_cand, fire_ok, fire;
    logic [7:0]  ext_cnt, shots;
    logic        inh_active, late_ok, fixed_block;
    logic [14:0] inh_elapsed;
    logic        rec_pend;
    logic [13:0] rec_elapsed;
    logic [4:0]  src_left, rec_left;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= tct_pkg::OFF_STATUS);
    endfunction

    function automatic logic [4:0] span_clamp(input logic [31:0] v);
        if (v < 32'(tct_pkg::SPAN_MIN))
            return tct_pkg::SPAN_MIN;
        if (v > 32'(tct_pkg::SPAN_MAX))
            return tct_pkg::SPAN_MAX;
        return v[4:0];
    endfunction

    function automatic logic [31:0] rd_val(input logic [7:0] a);
        unique case (a)
            tct_pkg::OFF_CTRL:    return 32'(cfg.ctrl);
            tct_pkg::OFF_PERIOD:  return 32'(cfg.period);
            tct_pkg::OFF_RDELAY:  return 32'(cfg.rec_delay);
            tct_pkg::OFF_HOLD:    return 32'(cfg.hold_sec);
            tct_pkg::OFF_WIDTH:   return 32'(cfg.width);
            tct_pkg::OFF_BLOCK:   return 32'(cfg.block);
            tct_pkg::OFF_INHIBIT: return 32'(cfg.inhibit);
            tct_pkg::OFF_EARLY:   return 32'(cfg.early);
            tct_pkg::OFF_LATE:    return 32'(cfg.late);
            tct_pkg::OFF_EXTN:    return 32'(cfg.ext_n);
            tct_pkg::OFF_FRATE:   return 32'(cfg.fixed_rate);
            tct_pkg::OFF_FCOUNT:  return 32'(cfg.fixed_count);
            tct_pkg::OFF_STATUS:  return {16'h0000, shots, 3'h0, ALARM_O, inh_active, state};
            default:              return 32'h0000_0000;
        endcase
    endfunction

    // ----------------------------------------
    // Millisecond tick
    // ----------------------------------------
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b0;
        end else if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
            tick     <= 1'b0;
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Bit 0 safety loop, 1 inhibit start, 2 external trigger
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s1    <= 3'h0;
            s2    <= 3'h0;
            s3    <= 3'h0;
            pin_q <= 3'h0;
            pin_d <= 3'h0;
        end else begin
            s1    <= {EXT_TRIG_I, INH_START_I, SAFE_LOOP_I};
            s2    <= s1;
            s3    <= s2;
            pin_q <= (s2 & s3) | (pin_q & (s2 ^ s3));
            pin_d <= pin_q;
        end
    end

    // ----------------------------------------
    // AXI4-Lite write
    // ----------------------------------------
    assign do_write = aw_held && w_held && !S_AXI_BVALID_O;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            aw_held         <= 1'b0;
            w_held          <= 1'b0;
            aw_addr         <= 8'h00;
            w_data          <= 32'h0000_0000;
            w_strb          <= 4'h0;
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O  <= 1'b1;
            S_AXI_BVALID_O  <= 1'b0;
            S_AXI_BRESP_O   <= tct_pkg::RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_held         <= 1'b1;
                aw_addr         <= S_AXI_AWADDR_I;
                S_AXI_AWREADY_O <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_held         <= 1'b1;
                w_data         <= S_AXI_WDATA_I;
                w_strb         <= S_AXI_WSTRB_I;
                S_AXI_WREADY_O <= 1'b0;
            end
            if (do_write) begin
                aw_held         <= 1'b0;
                w_held          <= 1'b0;
                S_AXI_BVALID_O  <= 1'b1;
                S_AXI_BRESP_O   <= addr_ok(aw_addr) ? tct_pkg::RESP_OKAY : tct_pkg::RESP_SLVERR;
            end
            if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_BVALID_O  <= 1'b0;
                S_AXI_AWREADY_O <= 1'b1;
                S_AXI_WREADY_O  <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge CLK_I or posedge RST_I) begin
        logic [31:0] v;
        logic [31:0] cur;
        v   = 32'h0000_0000;
        cur = rd_val(aw_addr);
        if (RST_I) begin
            cfg             <= '0;
            cfg.period      <= tct_pkg::PERIOD_RST;
            cfg.hold_sec    <= tct_pkg::SPAN_MIN;
            cfg.width       <= tct_pkg::SPAN_MIN;
            cfg.ext_n       <= tct_pkg::EXTN_RST;
            cfg.fixed_count <= tct_pkg::FCOUNT_RST;
            cfg.fixed_rate  <= tct_pkg::PERIOD_RST;
            cmd_go          <= 1'b0;
            cmd_adv         <= 1'b0;
            cmd_code        <= tct_pkg::CMD_NONE;
        end else begin
            cmd_go  <= 1'b0;
            cmd_adv <= 1'b0;
            if (do_write) begin
                // Byte lanes merge over the current readback
                for (int b = 0; b < 4; b++) begin
                    v[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : cur[b*8 +: 8];
                end
                unique case (aw_addr)
                    tct_pkg::OFF_CTRL:    cfg.ctrl <= v[6:0];
                    // Longer periods would overflow the timer
                    tct_pkg::OFF_PERIOD:  cfg.period <= (v > 32'(tct_pkg::PERIOD_CAP)) ?
                                              tct_pkg::PERIOD_MAX : v[13:0];
                    tct_pkg::OFF_RDELAY:  cfg.rec_delay <= v[13:0];
                    tct_pkg::OFF_HOLD:    cfg.hold_sec <= span_clamp(v);
                    tct_pkg::OFF_WIDTH:   cfg.width <= span_clamp(v);
                    tct_pkg::OFF_BLOCK:   cfg.block <= v[13:0];
                    tct_pkg::OFF_INHIBIT: cfg.inhibit <= v[13:0];
                    tct_pkg::OFF_EARLY:   cfg.early <= v[14:0];
                    tct_pkg::OFF_LATE:    cfg.late <= v[7:0];
                    tct_pkg::OFF_EXTN:    cfg.ext_n <= v[7:0];
                    tct_pkg::OFF_FRATE:   cfg.fixed_rate <= v[13:0];
                    tct_pkg::OFF_FCOUNT:  cfg.fixed_count <= v[7:0];
                    tct_pkg::OFF_CMD: begin
                        cmd_go   <= v[1:0] != tct_pkg::CMD_NONE;
                        cmd_code <= v[1:0];
                        cmd_adv  <= v[tct_pkg::CMD_ADV_BIT];
                    end
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite read
    // ----------------------------------------
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= 32'h0000_0000;
            S_AXI_RRESP_O   <= tct_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b1;
            S_AXI_RDATA_O   <= rd_val(S_AXI_ARADDR_I);
            S_AXI_RRESP_O   <= addr_ok(S_AXI_ARADDR_I) ? tct_pkg::RESP_OKAY : tct_pkg::RESP_SLVERR;
        end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_ARREADY_O <= 1'b1;
        end
    end

    // ----------------------------------------
    // Channel state
    // ----------------------------------------
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state <= tct_pkg::ST_STOP;
        end else if (cmd_go) begin
            unique case (cmd_code)
                tct_pkg::CMD_STOP: state <= tct_pkg::ST_STOP;
                tct_pkg::CMD_RUN:  state <= tct_pkg::ST_RUN;
                tct_pkg::CMD_HOLD: state <= tct_pkg::ST_HOLD;
                default:           state <= state;
            endcase
        end else if (cmd_adv) begin
            unique case (state)
                tct_pkg::ST_RUN:  state <= tct_pkg::ST_HOLD;
                tct_pkg::ST_HOLD: state <= tct_pkg::ST_STOP;
                tct_pkg::ST_STOP: state <= tct_pkg::ST_RUN;
                default:          state <= tct_pkg::ST_STOP;
            endcase
        end
    end

    // ----------------------------------------
    // Inhibit window
    // ----------------------------------------
    assign end_limit = cfg.ctrl.early_en ? cfg.early :
                       15'(cfg.block) + 15'(cfg.inhibit);
    assign late_ok   = cfg.ctrl.late_en && (inh_elapsed < 15'(cfg.late));

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            inh_active  <= 1'b0;
            inh_elapsed <= 15'h0000;
            fixed_now   <= 1'b0;
        end else begin
            fixed_now <= 1'b0;
            // Fixed-count mode forces inhibit on
            if (pin_q[1] && !pin_d[1] && (cfg.ctrl.inhibit_en || cfg.ctrl.fixed_en)) begin
                inh_active  <= 1'b1;
                inh_elapsed <= 15'h0000;
            end else if (inh_active && tick) begin
                inh_elapsed <= inh_elapsed + 15'h0001;
                if (inh_elapsed + 15'h0001 >= end_limit) begin
                    inh_active <= 1'b0;
                    fixed_now  <= cfg.ctrl.fixed_en;
                end
            end
        end
    end

    // ----------------------------------------
    // Time base and fire decision
    // ----------------------------------------
    assign cur_period = (cfg.ctrl.fixed_en ? 15'(cfg.fixed_rate) : 15'(cfg.period)) +
                        ((state == tct_pkg::ST_HOLD) ? 15'(cfg.hold_sec) * tct_pkg::MS_PER_SEC
                                                     : 15'h0000);
    assign tb_wrap    = tick && (tb_cnt + 15'h0001 >= cur_period);
    assign ext_fire   = pin_q[2] && !pin_d[2] &&
                        ((ext_cnt + 8'h01) >= cfg.ext_n);
    assign fire_cand  = fixed_now || (cfg.ctrl.ext_mode ? ext_fire : tb_wrap);
    assign fixed_block = cfg.ctrl.fixed_en && cfg.ctrl.strict &&
                         (shots >= cfg.fixed_count);
    assign fire_ok    = pin_q[0] && (state != tct_pkg::ST_STOP) && !fixed_block &&
                        (fixed_now || !inh_active || late_ok);
    assign fire       = fire_cand && fire_ok;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tb_cnt <= 15'h0000;
        end else if (fixed_now || tb_wrap) begin
            tb_cnt <= 15'h0000; // Fixed shot restarts the period at inhibit end
        end else if (tick) begin
            tb_cnt <= tb_cnt + 15'h0001;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ext_cnt <= 8'h00;
        end else if (!cfg.ctrl.ext_mode) begin
            ext_cnt <= 8'h00;
        end else if (pin_q[2] && !pin_d[2]) begin
            ext_cnt <= ext_fire ? 8'h00 : ext_cnt + 8'h01;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            shots <= 8'h00;
        end else if (pin_q[1] && !pin_d[1]) begin
            shots <= 8'h00;
        end else if (fire && shots != 8'hff) begin
            shots <= shots + 8'h01;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rec_pend    <= 1'b0;
            rec_elapsed <= 14'h0000;
            src_left    <= 5'h00;
            rec_left    <= 5'h00;
            SRC_TRIG_O  <= 1'b0;
            REC_TRIG_O  <= 1'b0;
            ALARM_O     <= 1'b0;
        end else begin
            ALARM_O <= !pin_q[0];
            if (fire) begin
                SRC_TRIG_O <= 1'b1;
                src_left   <= cfg.width;
            end else if (tick && src_left != 5'h00) begin
                src_left   <= src_left - 5'h01;
                SRC_TRIG_O <= src_left != 5'h01;
            end
            // Delay compared live so a new value acts on the pending shot
            if (fire && !cfg.ctrl.delay_en) begin
                REC_TRIG_O <= 1'b1;
                rec_left   <= cfg.width;
                rec_pend   <= 1'b0;
            end else if (!pin_q[0]) begin
                rec_pend <= 1'b0;
            end else if (rec_pend && tick && (rec_elapsed + 14'h0001 >= cfg.rec_delay)) begin
                rec_pend   <= 1'b0;
                REC_TRIG_O <= 1'b1;
                rec_left   <= cfg.width;
            end else if (tick && rec_left != 5'h00) begin
                rec_left   <= rec_left - 5'h01;
                REC_TRIG_O <= rec_left != 5'h01;
            end
            if (fire && cfg.ctrl.delay_en) begin
                rec_pend    <= 1'b1;
                rec_elapsed <= 14'h0000;
            end else if (rec_pend && tick) begin
                rec_elapsed <= rec_elapsed + 14'h0001;
            end
        end
    end

endmodule

// ==== tct_sva.sv ====
`timescale 1ns/1ps
module tct_sva (
    // Clock and reset
    input wire logic       CLK_I,
    input wire logic       RST_I,
    // Bus handshakes
    input wire logic       S_AXI_AWVALID_I,
    input wire logic       S_AXI_AWREADY_O,
    input wire logic       S_AXI_WVALID_I,
    input wire logic       S_AXI_WREADY_O,
    input wire logic       S_AXI_BVALID_O,
    input wire logic       S_AXI_BREADY_I,
    input wire logic [1:0] S_AXI_BRESP_O,
    input wire logic       S_AXI_ARVALID_I,
    input wire logic       S_AXI_ARREADY_O,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic       S_AXI_RVALID_O,
    input wire logic [1:0] S_AXI_RRESP_O,
    // Pins
    input wire logic       SAFE_LOOP_I,
    input wire logic       SRC_TRIG_O,
    input wire logic       ALARM_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);
    sequence wr_taken;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    endsequence
    // Eight cycles: the pin filter needs about four
    sequence loop_open;
        !SAFE_LOOP_I [*8];
    endsequence
    bresp_hold_a: assert property (
        S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write answer dropped early");
    write_answer_a: assert property (wr_taken |-> ##2 S_AXI_BVALID_O)
        else $error("write answer late");
    ready_back_a: assert property (
        S_AXI_BVALID_O && S_AXI_BREADY_I |=> S_AXI_AWREADY_O && S_AXI_WREADY_O)
        else $error("write channels not reopened");
    read_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read answer late");
    read_busy_a: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("read address taken while busy");
    bad_read_a: assert property (
        S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I > 8'h34 |=> S_AXI_RRESP_O == 2'h2)
        else $error("unmapped read not refused");
    alarm_open_a: assert property (loop_open |-> ALARM_O)
        else $error("alarm missing with loop open");
    loop_halt_a: assert property (loop_open |-> !$rose(SRC_TRIG_O))
        else $error("shot with loop open");
endmodule
bind tct_timebase tct_sva tct_sva_inst (
    .CLK_I(CLK_I), .RST_I(RST_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
    .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
    .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_RVALID_O(S_AXI_RVALID_O),
    .S_AXI_RRESP_O(S_AXI_RRESP_O), .SAFE_LOOP_I(SAFE_LOOP_I), .SRC_TRIG_O(SRC_TRIG_O), .ALARM_O(ALARM_O)
);

// ==== tct_far.sv ====
`timescale 1ns/1ps
module tct_far (
    // Clock and shots seen
    input  wire logic CLK_I,
    input  wire logic SRC_I,
    input  wire logic REC_I,
    // Trigger and master lines
    output logic      EXT_O = 1'b0,
    output logic      INH_O = 1'b0
);
    int   cyc = 0;
    int   src_n = 0;
    int   src_t = 0;
    int   rec_t = 0;
    int   gap = 0;
    int   hi = 0;
    int   wid = 0;
    logic src_q = 1'b0;
    logic rec_q = 1'b0;
    always @(posedge CLK_I) begin
        cyc <= cyc + 1;
        src_q <= SRC_I;
        rec_q <= REC_I;
        hi <= SRC_I ? hi + 1 : 0;
        if (!SRC_I && src_q) begin
            wid <= hi;
        end
        if (SRC_I && !src_q) begin
            src_n <= src_n + 1;
            src_t <= cyc;
            gap <= cyc - src_t;
        end
        if (REC_I && !rec_q) begin
            rec_t <= cyc;
        end
    end
    // Wide spacing so one shot ends before the next edge
    task automatic pulse(input logic m, input int c);
        repeat (c) begin
            {INH_O, EXT_O} <= m ? 2'h2 : 2'h1;
            repeat (4) @(posedge CLK_I);
            {INH_O, EXT_O} <= 2'h0;
            repeat (26) @(posedge CLK_I);
        end
    endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    localparam int TICK = 10;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        safe = 1'b1;
    logic [7:0]  aw = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [4:0]  req = 5'h00;
    logic        awr, wr, bv, arr, rv, src, rec, alm, ext, inh;
    logic [1:0]  brs, rrs, r;
    logic [31:0] rdt, q;
    int          bad_count = 0;
    int          tests_run = 0;
    int          seed = 40;
    int          s, n, k, m;
    always #12.5 clk = ~clk;
    tct_timebase #(.TICK_CYCLES(TICK)) tct_timebase_inst (
        .CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(aw), .S_AXI_AWVALID_I(req[4]), .S_AXI_AWREADY_O(awr),
        .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(req[3]), .S_AXI_WREADY_O(wr),
        .S_AXI_BRESP_O(brs), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(req[2]), .S_AXI_ARADDR_I(aw),
        .S_AXI_ARVALID_I(req[1]), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdt), .S_AXI_RRESP_O(rrs),
        .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(req[0]), .EXT_TRIG_I(ext), .INH_START_I(inh),
        .SAFE_LOOP_I(safe), .SRC_TRIG_O(src), .REC_TRIG_O(rec), .ALARM_O(alm));
    tct_far tct_far_inst (.CLK_I(clk), .SRC_I(src), .REC_I(rec), .EXT_O(ext), .INH_O(inh));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic lost;
        bad_count++;
        $display("ERROR %0t wait ran out", $time);
        complete_run();
    endtask
    // Request {awvalid, wvalid, bready, arvalid, rready}; each drops when taken
    // Answer ready raised only once the answer shows, so a held answer is seen
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic [1:0] h;
        n = 0;
        @(posedge clk);
        aw <= a;
        wd <= d;
        req <= w ? 5'h18 : 5'h02;
        do begin
            @(posedge clk);
            n++;
            h = w ? {bv, req[2]} : {rv, req[0]};
            req <= (h == 2'h3) ? 5'h00 : (req & ~{awr, wr, 1'b0, arr, 1'b0}) |
                                         (h[1] ? (w ? 5'h04 : 5'h01) : 5'h00);
        end while (h != 2'h3 && n < 50);
        q = rdt;
        r = w ? brs : rrs;
        if (n >= 50) lost();
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        chk(r, 2'h0);
    endtask
    task automatic shots(input int c);
        k = tct_far_inst.src_n + c;
        n = 0;
        while (tct_far_inst.src_n < k && n < 25000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 25000) lost();
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        bus(1'b0, tct_pkg::OFF_EXTN, 32'h0);
        chk(q, 32'h1);
        for (int i = 0; i < 2; i++) begin
            wreg(tct_pkg::OFF_PERIOD, i ? 32'h3ffc : 32'h3ffd + $unsigned($random(seed)) % 3);
            bus(1'b0, tct_pkg::OFF_PERIOD, 32'h0);
            chk(q, i ? 32'h3ffc : 32'h3e80);
            bus(i, 8'h3c, 32'h0);
            chk(r, tct_pkg::RESP_SLVERR);
        end
        $display("test registers done");
        wreg(tct_pkg::OFF_WIDTH, 32'h2);
        wreg(tct_pkg::OFF_PERIOD, 32'h5);
        wreg(tct_pkg::OFF_CMD, 32'h2);
        shots(2);
        chk(tct_far_inst.gap, 5 * TICK);
        chk(tct_far_inst.wid, 2 * TICK);
        chk(tct_far_inst.rec_t, tct_far_inst.src_t);
        for (int d = 3; d > 1; d--) begin
            wreg(tct_pkg::OFF_RDELAY, d);
            wreg(tct_pkg::OFF_CTRL, 32'h1);
            shots(2);
            repeat (4 * TICK) @(posedge clk);
            chk(tct_far_inst.rec_t - tct_far_inst.src_t, d * TICK);
        end
        $display("test run and delay done");
        wreg(tct_pkg::OFF_CTRL, 32'h0);
        wreg(tct_pkg::OFF_CMD, 32'h3);
        shots(2);
        chk(tct_far_inst.gap, (5 + tct_pkg::MS_PER_SEC) * TICK);
        for (int i = 0; i < 3; i++) begin
            wreg(tct_pkg::OFF_CMD, 32'h4);
            bus(1'b0, tct_pkg::OFF_STATUS, 32'h0);
            chk(q[2:0], 32'h1 << i);
        end
        wreg(tct_pkg::OFF_CMD, 32'h1);
        s = tct_far_inst.src_n;
        repeat (20 * TICK) @(posedge clk);
        chk(tct_far_inst.src_n, s);
        $display("test states done");
        m = 1 + $unsigned($random(seed)) % 4;
        wreg(tct_pkg::OFF_EXTN, m);
        wreg(tct_pkg::OFF_CTRL, 32'h4);
        wreg(tct_pkg::OFF_WIDTH, 32'h1);
        wreg(tct_pkg::OFF_CMD, 32'h2);
        s = tct_far_inst.src_n;
        tct_far_inst.pulse(1'b0, 12);
        chk(tct_far_inst.src_n - s, 12 / m);
        $display("test external done");
        wreg(tct_pkg::OFF_BLOCK, 32'h5);
        wreg(tct_pkg::OFF_INHIBIT, 32'h5);
        for (int e = 1; e >= 0; e--) begin
            wreg(tct_pkg::OFF_CTRL, e << 1);
            tct_far_inst.pulse(1'b1, 1);
            s = tct_far_inst.src_n;
            bus(1'b0, tct_pkg::OFF_STATUS, 32'h0);
            chk(q[3], e);
            repeat (5 * TICK) @(posedge clk);
            if (e) chk(tct_far_inst.src_n, s);
        end
        $display("test inhibit done");
        wreg(tct_pkg::OFF_FRATE, 32'h3);
        wreg(tct_pkg::OFF_FCOUNT, 32'h2);
        wreg(tct_pkg::OFF_EARLY, 32'h4);
        // Strict, then free running, then early start; inhibit itself only forced
        for (int f = 0; f < 3; f++) begin
            wreg(tct_pkg::OFF_CTRL, f == 0 ? 32'h18 : f == 1 ? 32'h08 : 32'h28);
            tct_far_inst.pulse(1'b1, 1);
            s = tct_far_inst.src_n;
            repeat (170) @(posedge clk);
            chk(tct_far_inst.src_n - s, 2 * f + 2);
        end
        $display("test fixed count done");
        safe <= 1'b0;
        repeat (20) @(posedge clk);
        bus(1'b0, tct_pkg::OFF_STATUS, 32'h0);
        chk({alm, q[4]}, 2'h3);
        safe <= 1'b1;
        repeat (20) @(posedge clk);
        chk(alm, 1'b0);
        $display("test safety done");
        complete_run();
    end
endmodule
